// >>> dv/mac_vlan_wakeup_detect_tb_top.sv
// Self-checking bench for the tag and wake-up block
`timescale 1ns/100ps
module mac_vlan_wakeup_detect_tb_top;
    import mvw_pkg::*;
    localparam logic [47:0] STATION = 48'h021122334455;
    logic        clk = 1'b0;
    logic        arst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        rx_valid, rx_last, rx_good, rx_done, rx_tag_first, rx_tag_second;
    logic        rx_too_long, power_save, wake_event;
    logic [7:0]  paddr, rx_data;
    logic [31:0] pwdata, prdata, rd;
    int          errors = 0;
    int          checks_done = 0;
    logic [7:0]  rst_addr [3] = '{ADDR_TAG_FIRST, ADDR_TAG_SECOND, ADDR_WAKE_CS};
    int          lens [4] = '{1522, 1523, 1518, 1519};
    logic [15:0] tags [4] = '{16'h8100, 16'h8100, 16'h0800, 16'h0800};
    logic [2:0]  exps [4] = '{3'b110, 3'b111, 3'b000, 3'b001};
    always #12.5 clk = ~clk;
    mvw_top i_mvw_top (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_good(rx_good), .station_addr(STATION), .rx_done(rx_done),
        .rx_tag_first(rx_tag_first), .rx_tag_second(rx_tag_second),
        .rx_too_long(rx_too_long), .power_save(power_save), .wake_event(wake_event),
        .irq(irq));
    mvw_rx_model #(.STATION(STATION)) i_mvw_rx_model (.clk(clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_good(rx_good));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Held until pready high; one idle edge after
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic give_verdict;
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        give_verdict;
    end
    initial begin
        {arst_n, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (rst_addr[i]) begin
            apb(1'b0, rst_addr[i], 32'h0, rd);
            chk(rd, REG_RESET);
        end
        apb(1'b1, ADDR_TAG_FIRST, 32'h00008100, rd);
        apb(1'b1, ADDR_TAG_SECOND, 32'hFFFF8100, rd);
        apb(1'b0, ADDR_TAG_SECOND, 32'h0, rd);
        chk(rd, 32'h00008100);
        for (int i = 0; i < 9; i++) apb(1'b1, ADDR_WAKE_STORE, 32'h1 << i, rd);
        apb(1'b0, ADDR_WAKE_STORE, 32'h0, rd);
        chk(rd, 32'h00000000);
        apb(1'b0, 8'h00, 32'h0, rd);
        chk({31'h0, pslverr}, 32'h1);
        // Both sides of each length limit
        for (int i = 0; i < 4; i++) begin
            i_mvw_rx_model.send(lens[i], tags[i], 8'h01, 1'b0);
            chk({29'h0, rx_tag_first, rx_tag_second, rx_too_long}, {29'h0, exps[i]});
        end
        i_mvw_rx_model.send(128, 16'h0800, 8'h01, 1'b1);
        apb(1'b0, ADDR_WAKE_CS, 32'h0, rd);
        chk(rd, 32'h00000000);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h1, rd);
        apb(1'b1, ADDR_WAKE_CS, 32'h2, rd);
        apb(1'b1, ADDR_PM_CTRL, 32'h1, rd);
        i_mvw_rx_model.send(128, 16'h0800, 8'h01, 1'b1);
        apb(1'b0, ADDR_WAKE_CS, 32'h0, rd);
        chk(rd, 32'h00000022);
        chk({30'h0, irq, power_save}, 32'h2);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1, rd);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, ADDR_WAKE_CS, 32'h0, rd);
        chk(rd, 32'h00000022);
        apb(1'b1, ADDR_WAKE_CS, 32'h22, rd);
        apb(1'b0, ADDR_WAKE_CS, 32'h0, rd);
        chk(rd, 32'h00000002);
        apb(1'b1, ADDR_WAKE_CS, 32'h200, rd);
        apb(1'b1, ADDR_PM_CTRL, 32'h1, rd);
        i_mvw_rx_model.send(64, 16'h0800, 8'h01, 1'b0);
        chk({31'h0, power_save}, 32'h1);
        i_mvw_rx_model.send(64, 16'h0800, 8'h00, 1'b0);
        chk({31'h0, power_save}, 32'h0);
        give_verdict;
    end
endmodule // mac_vlan_wakeup_detect_tb_top

// >>> dv/mvw_monitor.sv
// Assertion checker for the tag and wake-up block ports
`timescale 1ns/100ps
module mvw_monitor
    import mvw_pkg::*;
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pslverr,
    input wire logic              rx_valid,
    input wire logic              rx_last,
    input wire logic              rx_done,
    input wire logic              rx_tag_first,
    input wire logic              rx_tag_second,
    input wire logic              rx_too_long,
    input wire logic              power_save,
    input wire logic              wake_event,
    input wire logic              irq
);
    logic [15:0] cnt_q;
    logic [15:0] len_q;
    // Own byte count of the frame
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 16'h0000;
            len_q <= 16'h0000;
        end else if (rx_valid) begin
            cnt_q <= rx_last ? 16'h0000 : cnt_q + 16'h0001;
            len_q <= rx_last ? cnt_q + 16'h0001 : len_q;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_done_after_last: assert property ((rx_valid && rx_last) |=> rx_done)
        else $error("no result pulse after last byte");
    a_results_hold: assert property (!rx_done |->
        $stable({rx_tag_first, rx_tag_second, rx_too_long}))
        else $error("results moved without frame end");
    a_len_limit: assert property (rx_done |-> rx_too_long ==
        (len_q > ((rx_tag_first || rx_tag_second) ? LEN_TAGGED : LEN_UNTAGGED)))
        else $error("too long flag wrong");
    a_store_reads_zero: assert property (psel && !penable && !pwrite &&
        paddr == ADDR_WAKE_STORE |=> prdata == 32'h00000000 && !pslverr)
        else $error("filter store read back data");
    a_wake_cause: assert property (wake_event |-> $past(power_save) && !power_save)
        else $error("wake pulse without leaving power save");
    a_save_entry: assert property ($rose(power_save) |->
        $past(psel && penable && pwrite && paddr == ADDR_PM_CTRL))
        else $error("power save without write");
    a_irq_rise_cause: assert property ($rose(irq) |-> rx_done || $past(rx_done) ||
        $past(psel && penable && pwrite))
        else $error("irq rose without cause");
    a_flag_sticky: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("irq fell without write");
endmodule // mvw_monitor

bind mvw_top mvw_monitor i_mvw_monitor (.*);

// >>> dv/mvw_rx_model.sv
// Receive path source that streams test frames byte by byte
`timescale 1ns/100ps
module mvw_rx_model #(
    parameter logic [47:0] STATION = 48'h000000000000
) (
    input wire logic  clk,
    output logic       rx_valid,
    output logic [7:0] rx_data,
    output logic       rx_last,
    output logic       rx_good
);
    initial begin
        {rx_valid, rx_last, rx_good} = 3'b000;
        rx_data = 8'h5A;
    end
    // Tag bytes at 12 and 13, magic sync and repeats after them
    task automatic send(input int n, input logic [15:0] tag, input logic [7:0] dst,
                        input logic mg);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            case (i)
                12: b = tag[15:8];
                13: b = tag[7:0];
                default: b = (i < 6) ? dst : i[7:0];
            endcase
            if (mg && i >= 14 && i < 20) b = 8'hFF;
            if (mg && i >= 20 && i < 116) b = STATION[47 - 8 * ((i - 20) % 6) -: 8];
            {rx_valid, rx_good} <= 2'b11;
            rx_data <= b;
            rx_last <= (i == n - 1);
            @(posedge clk);
        end
        // Idle lines do not keep the last byte
        {rx_valid, rx_last, rx_good} <= 3'b000;
        rx_data <= ~b;
        repeat (3) @(posedge clk);
    endtask
endmodule // mvw_rx_model

// >>> rtl/mvw_pkg.sv
// Constants for the VLAN tag and wake-up detect block
package mvw_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    localparam logic [31:0] REG_RESET       = 32'h00000000;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_TAG_FIRST   = 8'h09;
    localparam logic [7:0]  IDX_TAG_SECOND  = 8'h0A;
    localparam logic [7:0]  IDX_WAKE_STORE  = 8'h0B;
    localparam logic [7:0]  IDX_WAKE_CS     = 8'h0C;
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h0D;
    localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'h0E;
    localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h0F;
    localparam logic [7:0]  IDX_PM_CTRL     = 8'h10;
    localparam logic [7:0]  ADDR_TAG_FIRST  = IDX_TAG_FIRST << 2;
    localparam logic [7:0]  ADDR_TAG_SECOND = IDX_TAG_SECOND << 2;
    localparam logic [7:0]  ADDR_WAKE_STORE = IDX_WAKE_STORE << 2;
    localparam logic [7:0]  ADDR_WAKE_CS    = IDX_WAKE_CS << 2;
    localparam logic [7:0]  ADDR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
    localparam logic [7:0]  ADDR_IRQ_CLEAR  = IDX_IRQ_CLEAR << 2;
    localparam logic [7:0]  ADDR_IRQ_ENABLE = IDX_IRQ_ENABLE << 2;
    localparam logic [7:0]  ADDR_PM_CTRL    = IDX_PM_CTRL << 2;
    // Tag identifier field
    localparam int          TAG_ID_W        = 16;
    // Wake control and status fields
    localparam int          WC_MP_EN        = 1;
    localparam int          WC_WF_EN        = 2;
    localparam int          WC_MP_SEEN      = 5;
    localparam int          WC_WF_SEEN      = 6;
    localparam int          WC_GU_EN        = 9;
    localparam logic [31:0] WC_RW_MASK      = 32'h00000206;
    // Interrupt status bits
    localparam int          IRQ_W           = 4;
    localparam int          IRQ_MAGIC       = 0;
    localparam int          IRQ_WFRAME      = 1;
    localparam int          IRQ_UNICAST     = 2;
    localparam int          IRQ_TOO_LONG    = 3;
    // Power control bits
    localparam int          PM_ENTER        = 0;
    localparam int          PM_SOFT_RST     = 1;
    // Frame layout: zero-based positions of the 13th and 14th byte
    localparam int          TAG_POS_HI      = 12;
    localparam int          TAG_POS_LO      = 13;
    localparam int          LEN_W           = 16;
    localparam logic [15:0] LEN_UNTAGGED    = 16'd1518;
    localparam logic [15:0] LEN_TAGGED      = 16'd1522;
    // Wake-up filter store
    localparam int          FILT_ENTRIES    = 8;
    localparam int          FILT_SPAN       = 32;
    localparam logic [15:0] CRC_POLY        = 16'h8005;
    localparam logic [15:0] CRC_INIT        = 16'hFFFF;
    // Magic packet layout
    localparam logic [7:0]  MAGIC_SYNC_BYTE = 8'hFF;
    localparam logic [2:0]  MAGIC_SYNC_LEN  = 3'd6;
    localparam logic [4:0]  MAGIC_REPS      = 5'd16;
    localparam logic [2:0]  MAC_BYTES       = 3'd6;
endpackage

// >>> rtl/mvw_top.sv
// VLAN tag detection, frame length check and remote wake-up logic with APB registers
//
// Notes on behaviour
// R1 - Compare first tag identifier with received bytes 13 and 14 of each frame.
// R2 - Compare low sixteen bits of second tag identifier with bytes 13 and 14.
// R3 - Tagged frames may be 1522 bytes long instead of 1518 before flagged.
// R4 - Software programs tag identifiers with 0x8100 before using tag detection.
// R5 - After any reset, first filter store write fills entry zero, then next.
// R6 - Filter write pointer wraps to entry zero after all eight entries.
// R7 - Filter store is write-only; reading it returns zero.
// R8 - With unicast wake enabled, a frame with address bit 0 clear wakes.
// R9 - A valid wake-up frame sets the wake frame received flag.
// R10 - A valid magic packet sets the magic packet received flag.
// R11 - Wake frame enable turns on filter matching of received frames.
// R12 - Magic packet enable turns on magic packet detection.
// R13 - Tag registers and wake control register reset to all zeros.
// R14 - Received flags stay set until reset or software writes one to clear.
`timescale 1ns/100ps
module mvw_top
    import mvw_pkg::*;
#(
    parameter int FILTER_ENTRIES = mvw_pkg::FILT_ENTRIES
) (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [mvw_pkg::ADDR_W-1:0] paddr,
    input  wire logic [mvw_pkg::DATA_W-1:0] pwdata,
    output logic      [mvw_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       rx_valid,
    input  wire logic [7:0]                 rx_data,
    input  wire logic                       rx_last,
    input  wire logic                       rx_good,
    input  wire logic [47:0]                station_addr,
    output logic                            rx_done,
    output logic                            rx_tag_first,
    output logic                            rx_tag_second,
    output logic                            rx_too_long,
    output logic                            power_save,
    output logic                            wake_event,
    output logic                            irq
);
    import mvw_pkg::*;

    if (FILTER_ENTRIES != 8) begin : g_chk
        $error("mvw_top: the filter store holds exactly eight entries");
    end

    logic [31:0]       tag_first_q, tag_first_d;
    logic [31:0]       tag_second_q, tag_second_d;
    logic [31:0]       wake_cs_q, wake_cs_d;
    logic [IRQ_W-1:0]  irq_stat_q, irq_stat_d;
    logic [IRQ_W-1:0]  irq_en_q, irq_en_d;
    logic              pm_q, pm_d;
    logic [31:0]       prdata_d;
    logic              pslverr_d;
    logic              setup, wr_acc;
    logic              addr_ok;
    logic              soft_rst;
    logic              store_we;
    logic [31:0]       wake_clr;
    logic [IRQ_W-1:0]  irq_clr;

    logic [LEN_W-1:0]  len_q, len_d;
    logic [7:0]        tag_hi_q, tag_hi_d;
    logic              tag1_q, tag1_d;
    logic              tag2_q, tag2_d;
    logic              ucast_q, ucast_d;
    logic              done_d, too_long_d, tag1_o_d, tag2_o_d;
    logic              rx_tag1_q, rx_tag2_q, rx_long_q;
    logic [LEN_W-1:0]  frame_len;
    logic [LEN_W-1:0]  len_limit;
    logic              frame_end;
    logic              ucast_hit;
    logic              magic_hit, frame_hit;
    logic              wake_d;

    // APB: zero wait states, read data and error captured in the setup cycle
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb begin
        unique case (paddr)
            ADDR_TAG_FIRST, ADDR_TAG_SECOND, ADDR_WAKE_STORE, ADDR_WAKE_CS,
            ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE, ADDR_PM_CTRL: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_comb begin
        prdata_d  = prdata;
        pslverr_d = pslverr;
        if (setup) begin
            pslverr_d = !addr_ok;
            prdata_d  = '0;
            if (!pwrite) begin
                unique case (paddr)
                    ADDR_TAG_FIRST:  prdata_d = {16'h0000, tag_first_q[TAG_ID_W-1:0]};
                    ADDR_TAG_SECOND: prdata_d = {16'h0000, tag_second_q[TAG_ID_W-1:0]};
                    ADDR_WAKE_CS:    prdata_d = wake_cs_q;
                    ADDR_IRQ_STATUS: prdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
                    ADDR_IRQ_ENABLE: prdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_en_q};
                    ADDR_PM_CTRL:    prdata_d = {31'h00000000, pm_q};
                    // R7 - no read back
                    default:         prdata_d = '0;
                endcase
            end
        end
    end

    assign soft_rst = wr_acc && (paddr == ADDR_PM_CTRL) && pwdata[PM_SOFT_RST];
    // R5 - auto-indexed store write
    assign store_we = wr_acc && (paddr == ADDR_WAKE_STORE);
    assign wake_clr = (wr_acc && paddr == ADDR_WAKE_CS) ?
                      (pwdata & ((32'h1 << WC_MP_SEEN) | (32'h1 << WC_WF_SEEN))) : '0;
    assign irq_clr  = (wr_acc && paddr == ADDR_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : '0;

    // Configuration registers
    always_comb begin
        tag_first_d  = tag_first_q;
        tag_second_d = tag_second_q;
        wake_cs_d    = wake_cs_q;
        irq_en_d     = irq_en_q;
        if (wr_acc && paddr == ADDR_TAG_FIRST) begin
            tag_first_d = {16'h0000, pwdata[TAG_ID_W-1:0]};
        end
        if (wr_acc && paddr == ADDR_TAG_SECOND) begin
            tag_second_d = {16'h0000, pwdata[TAG_ID_W-1:0]};
        end
        if (wr_acc && paddr == ADDR_WAKE_CS) begin
            wake_cs_d = (wake_cs_q & ~WC_RW_MASK) | (pwdata & WC_RW_MASK);
        end
        // R14 - write one clears
        wake_cs_d = wake_cs_d & ~wake_clr;
        // R10 - magic flag set wins
        if (magic_hit) begin
            wake_cs_d[WC_MP_SEEN] = 1'b1;
        end
        // R9 - wake frame flag set wins
        if (frame_hit) begin
            wake_cs_d[WC_WF_SEEN] = 1'b1;
        end
        if (wr_acc && paddr == ADDR_IRQ_ENABLE) begin
            irq_en_d = pwdata[IRQ_W-1:0];
        end
        // R13 - soft reset clears
        if (soft_rst) begin
            tag_first_d  = REG_RESET;
            tag_second_d = REG_RESET;
            wake_cs_d    = REG_RESET;
        end
    end

    // Frame end is the byte with rx_last
    assign frame_end = rx_valid && rx_last;
    assign frame_len = (len_q == {LEN_W{1'b1}}) ? len_q : len_q + 16'd1;

    always_comb begin
        len_d    = len_q;
        tag_hi_d = tag_hi_q;
        tag1_d   = tag1_q;
        tag2_d   = tag2_q;
        ucast_d  = ucast_q;
        if (rx_valid) begin
            len_d = frame_len;
            if (len_q == 16'd0) begin
                ucast_d = !rx_data[0];
            end
            if (len_q == LEN_W'(TAG_POS_HI)) begin
                tag_hi_d = rx_data;
            end
            if (len_q == LEN_W'(TAG_POS_LO)) begin
                // R1 - first tag compare
                tag1_d = ({tag_hi_q, rx_data} == tag_first_q[TAG_ID_W-1:0]);
                // R2 - second tag compare
                tag2_d = ({tag_hi_q, rx_data} == tag_second_q[TAG_ID_W-1:0]);
            end
        end
        // R3 - limit taken before the tag clear
        len_limit  = (tag1_d || tag2_d) ? LEN_TAGGED : LEN_UNTAGGED;
        done_d     = frame_end;
        tag1_o_d   = frame_end ? tag1_d : rx_tag1_q;
        tag2_o_d   = frame_end ? tag2_d : rx_tag2_q;
        too_long_d = frame_end ? (frame_len > len_limit) : rx_long_q;
        if (frame_end) begin
            len_d   = '0;
            tag1_d  = 1'b0;
            tag2_d  = 1'b0;
            ucast_d = 1'b0;
        end
    end

    // R8 - global unicast wake
    assign ucast_hit = frame_end && rx_good && wake_cs_q[WC_GU_EN] &&
                       (len_q != 16'd0 ? ucast_q : !rx_data[0]);

    // Any wake source leaves power save
    always_comb begin
        wake_d = pm_q && (magic_hit || frame_hit || ucast_hit);
        pm_d   = pm_q;
        if (wr_acc && paddr == ADDR_PM_CTRL) begin
            pm_d = pwdata[PM_ENTER];
        end
        if (wake_d) begin
            pm_d = 1'b0;
        end
    end

    // Sticky interrupt status, set wins over clear
    always_comb begin
        irq_stat_d = irq_stat_q & ~irq_clr;
        if (magic_hit) begin
            irq_stat_d[IRQ_MAGIC] = 1'b1;
        end
        if (frame_hit) begin
            irq_stat_d[IRQ_WFRAME] = 1'b1;
        end
        if (ucast_hit && pm_q) begin
            irq_stat_d[IRQ_UNICAST] = 1'b1;
        end
        if (frame_end && too_long_d) begin
            irq_stat_d[IRQ_TOO_LONG] = 1'b1;
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    // Detector results are registered pulses
    mvw_wake_detect #(
        .ENTRIES      (FILTER_ENTRIES),
        .SPAN         (FILT_SPAN)
    ) u_detect (
        .clk          (clk),
        .arst_n       (arst_n),
        // R6 - pointer wraps inside
        .soft_rst     (soft_rst),
        .store_we     (store_we),
        .store_wdata  (pwdata),
        .rx_valid     (rx_valid),
        .rx_data      (rx_data),
        .rx_last      (rx_last),
        .rx_good      (rx_good),
        .station_addr (station_addr),
        // R12 - magic detect enable
        .magic_en     (wake_cs_q[WC_MP_EN]),
        // R11 - filter detect enable
        .frame_en     (wake_cs_q[WC_WF_EN]),
        .magic_hit    (magic_hit),
        .frame_hit    (frame_hit)
    );

    assign rx_tag_first  = rx_tag1_q;
    assign rx_tag_second = rx_tag2_q;
    assign rx_too_long   = rx_long_q;
    assign power_save    = pm_q;

    // R13 - zero after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tag_first_q  <= REG_RESET;
            tag_second_q <= REG_RESET;
            wake_cs_q    <= REG_RESET;
            irq_stat_q   <= '0;
            irq_en_q     <= '0;
            pm_q         <= 1'b0;
            prdata       <= '0;
            pslverr      <= 1'b0;
            len_q        <= '0;
            tag_hi_q     <= '0;
            tag1_q       <= 1'b0;
            tag2_q       <= 1'b0;
            ucast_q      <= 1'b0;
            rx_done      <= 1'b0;
            rx_tag1_q    <= 1'b0;
            rx_tag2_q    <= 1'b0;
            rx_long_q    <= 1'b0;
            wake_event   <= 1'b0;
        end else begin
            tag_first_q  <= tag_first_d;
            tag_second_q <= tag_second_d;
            wake_cs_q    <= wake_cs_d;
            irq_stat_q   <= irq_stat_d;
            irq_en_q     <= irq_en_d;
            pm_q         <= pm_d;
            prdata       <= prdata_d;
            pslverr      <= pslverr_d;
            len_q        <= len_d;
            tag_hi_q     <= tag_hi_d;
            tag1_q       <= tag1_d;
            tag2_q       <= tag2_d;
            ucast_q      <= ucast_d;
            rx_done      <= done_d;
            rx_tag1_q    <= tag1_o_d;
            rx_tag2_q    <= tag2_o_d;
            rx_long_q    <= too_long_d;
            wake_event   <= wake_d;
        end
    end
endmodule // mvw_top

// >>> rtl/mvw_wake_detect.sv
// Magic packet and wake-up frame filter detection
`timescale 1ns/100ps
module mvw_wake_detect
    import mvw_pkg::*;
#(
    parameter int ENTRIES = mvw_pkg::FILT_ENTRIES,
    parameter int SPAN    = mvw_pkg::FILT_SPAN
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        soft_rst,
    input  wire logic        store_we,
    input  wire logic [31:0] store_wdata,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    input  wire logic        rx_good,
    input  wire logic [47:0] station_addr,
    input  wire logic        magic_en,
    input  wire logic        frame_en,
    output logic             magic_hit,
    output logic             frame_hit
);
    localparam int NFILT = ENTRIES / 2;
    localparam int PTR_W = $clog2(ENTRIES);

    if (ENTRIES < 2 || (ENTRIES % 2) != 0 || (1 << PTR_W) != ENTRIES || SPAN != 32) begin : g_chk
        $error("mvw_wake_detect: ENTRIES must be an even power of two and SPAN 32");
    end

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    logic [31:0]      store_q [ENTRIES];
    logic [31:0]      store_d [ENTRIES];
    logic [PTR_W-1:0] ptr_q, ptr_d;
    logic [5:0]       pos_q, pos_d;
    logic [15:0]      crc_q [NFILT];
    logic [15:0]      crc_d [NFILT];
    logic [NFILT-1:0] filt_match;
    logic [2:0]       sync_q, sync_d;
    logic [4:0]       rep_q, rep_d;
    logic [2:0]       mpos_q, mpos_d;
    logic             found_q, found_d;
    logic [7:0]       mac_byte;
    logic             magic_hit_d, frame_hit_d;

    // Store write: entry k mask, entry k+NFILT expected CRC
    always_comb begin
        for (int k = 0; k < ENTRIES; k++) begin
            store_d[k] = store_q[k];
        end
        ptr_d = ptr_q;
        if (soft_rst) begin
            ptr_d = '0;
        end else if (store_we) begin
            store_d[ptr_q] = store_wdata;
            // Pointer wraps after the last entry
            ptr_d = ptr_q + 1'b1;
        end
    end

    assign mac_byte = station_addr[8*(32'(MAC_BYTES) - 1 - 32'(mpos_q)) +: 8];

    // Filters hash masked bytes of the first SPAN bytes
    for (genvar k = 0; k < NFILT; k++) begin : g_filt
        always_comb begin
            crc_d[k] = crc_q[k];
            if (rx_valid && pos_q < 6'(SPAN) && store_q[k][pos_q[4:0]]) begin
                crc_d[k] = crc16_byte(crc_q[k], rx_data);
            end
            filt_match[k] = (store_q[k] != '0) && (crc_d[k] == store_q[k+NFILT][15:0]);
            if (rx_valid && rx_last) begin
                crc_d[k] = CRC_INIT;
            end
        end
    end

    always_comb begin
        pos_d  = pos_q;
        sync_d = sync_q;
        rep_d  = rep_q;
        mpos_d = mpos_q;
        found_d = found_q;
        if (rx_valid) begin
            if (pos_q != 6'h3F) begin
                pos_d = pos_q + 6'h01;
            end
            if (found_q) begin
                found_d = 1'b1;
            end else if (sync_q < MAGIC_SYNC_LEN) begin
                sync_d = (rx_data == MAGIC_SYNC_BYTE) ? sync_q + 3'd1 : 3'd0;
            end else if (rx_data == mac_byte) begin
                mpos_d = mpos_q + 3'd1;
                if (mpos_q == MAC_BYTES - 3'd1) begin
                    mpos_d = 3'd0;
                    rep_d  = rep_q + 5'd1;
                    found_d = (rep_q == MAGIC_REPS - 5'd1);
                end
            end else if (!(rx_data == MAGIC_SYNC_BYTE && mpos_q == 3'd0 && rep_q == 5'd0)) begin
                // Mismatch restarts the search; an FF may open a new sync run
                sync_d = (rx_data == MAGIC_SYNC_BYTE) ? 3'd1 : 3'd0;
                rep_d  = 5'd0;
                mpos_d = 3'd0;
            end
        end
        magic_hit_d = rx_valid && rx_last && rx_good && magic_en && found_d;
        frame_hit_d = rx_valid && rx_last && rx_good && frame_en && (|filt_match);
        if (rx_valid && rx_last) begin
            pos_d   = '0;
            sync_d  = '0;
            rep_d   = '0;
            mpos_d  = '0;
            found_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < ENTRIES; k++) begin
                store_q[k] <= REG_RESET;
            end
            for (int k = 0; k < NFILT; k++) begin
                crc_q[k] <= CRC_INIT;
            end
            ptr_q     <= '0;
            pos_q     <= '0;
            sync_q    <= '0;
            rep_q     <= '0;
            mpos_q    <= '0;
            found_q   <= 1'b0;
            magic_hit <= 1'b0;
            frame_hit <= 1'b0;
        end else begin
            for (int k = 0; k < ENTRIES; k++) begin
                store_q[k] <= store_d[k];
            end
            for (int k = 0; k < NFILT; k++) begin
                crc_q[k] <= crc_d[k];
            end
            ptr_q     <= ptr_d;
            pos_q     <= pos_d;
            sync_q    <= sync_d;
            rep_q     <= rep_d;
            mpos_q    <= mpos_d;
            found_q   <= found_d;
            magic_hit <= magic_hit_d;
            frame_hit <= frame_hit_d;
        end
    end
endmodule // mvw_wake_detect
